// ==== src/dcs_pkg.sv ====
// Package: register map, field layout and widths of the DMA channel status view
package dcs_pkg;
  localparam int NUM_CHAN = 12;
  localparam int NUM_LVL = 4;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int IDX_W = 5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CHANNEL_INTERRUPT_SUMMARY_OFS = 8'h24;
  localparam logic [7:0] CHANNEL_BUSY_FLAGS_OFS = 8'h28;
  localparam logic [7:0] CHANNEL_PENDING_FLAGS_OFS = 8'h2c;
  localparam logic [7:0] ACTIVE_CHANNEL_STATE_OFS = 8'h30;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h50;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h54;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Active channel register fields
  // ----------------------------------------------------------------
  localparam int ACT_CNT_LSB = 16;
  localparam int ACT_BUSY_BIT = 15;
  localparam int ACT_IDX_LSB = 8;
  localparam int ACT_LVL_LSB = 0;

  // Interrupt status bits of this block
  localparam int IRQ_W = 3;
  localparam int IRQ_GRANT_BIT = 0;
  localparam int IRQ_WRBACK_BIT = 1;
  localparam int IRQ_CHINT_BIT = 2;

  // Active slot states
  typedef enum logic [0:0] {
    DCS_IDLE = 1'b0,
    DCS_LOADED = 1'b1
  } dcs_slot_type;
endpackage : dcs_pkg

// ==== src/dcs_chan_flag.sv ====
// Per-channel busy and pending flag pair
module dcs_chan_flag (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic done_i,
  input wire logic bus_err_i,
  input wire logic disable_i,
  input wire logic pend_req_i,
  input wire logic exec_start_i,
  output logic busy_o,
  output logic pend_o
);
  typedef struct packed {
    logic busy;
    logic pend;
  } dcs_flag_type;

  dcs_flag_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (start_i) begin
      s_d.busy = 1'b1;
    end
    if (done_i || bus_err_i || disable_i) begin
      s_d.busy = 1'b0;
    end
    if (pend_req_i) begin
      s_d.pend = 1'b1;
    end
    // pending clear causes; abort wins over new request
    if (exec_start_i || bus_err_i || disable_i) begin
      s_d.pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = s_q.busy;
  assign pend_o = s_q.pend;
endmodule // dcs_chan_flag

// ==== src/dcs_status_view.sv ====
// Top: status view of a twelve-channel DMA controller; only the IRQ status and mask registers take writes

module dcs_status_view (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [dcs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Channel engine events
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_irq_flags_i,
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_irq_enables_i,
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_start_i,
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_done_i,
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_bus_err_i,
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_disable_i,
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_pend_req_i,
  input wire logic [dcs_pkg::NUM_CHAN-1:0] chan_exec_start_i,
  input wire logic [1:0] chan_level_i [dcs_pkg::NUM_CHAN],
  // Arbiter and write-back memory
  input wire logic grant_i,
  input wire logic [dcs_pkg::IDX_W-1:0] grant_index_i,
  input wire logic count_load_i,
  input wire logic [dcs_pkg::CNT_W-1:0] count_load_data_i,
  input wire logic count_update_i,
  input wire logic [dcs_pkg::CNT_W-1:0] count_update_data_i,
  output logic wrback_valid_o,
  output logic [dcs_pkg::IDX_W-1:0] wrback_index_o,
  output logic [dcs_pkg::CNT_W-1:0] wrback_count_o,
  // Interrupt
  output logic irq_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [dcs_pkg::NUM_CHAN-1:0] chint;
    logic [dcs_pkg::CNT_W-1:0] count;
    logic active_busy_flag;
    logic [dcs_pkg::IDX_W-1:0] index;
    dcs_pkg::dcs_slot_type slot;
    logic wb_valid;
    logic [dcs_pkg::IDX_W-1:0] wb_index;
    logic [dcs_pkg::CNT_W-1:0] wb_count;
    logic [dcs_pkg::IRQ_W-1:0] irq_status;
    logic [dcs_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
  } dcs_state_type;

  dcs_state_type s_q, s_d;

  logic [dcs_pkg::NUM_CHAN-1:0] busy_w;
  logic [dcs_pkg::NUM_CHAN-1:0] pend_w;
  logic [dcs_pkg::NUM_LVL-1:0] lvl_w;
  logic [dcs_pkg::IRQ_W-1:0] irq_evt;
  logic [31:0] act_word;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Per-channel busy and pending flags
  // ----------------------------------------------------------------
  for (genvar g = 0; g < dcs_pkg::NUM_CHAN; g++) begin : g_chan
    dcs_chan_flag u_flag (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .start_i(chan_start_i[g]),
      .done_i(chan_done_i[g]),
      .bus_err_i(chan_bus_err_i[g]),
      .disable_i(chan_disable_i[g]),
      .pend_req_i(chan_pend_req_i[g]),
      .exec_start_i(chan_exec_start_i[g]),
      .busy_o(busy_w[g]),
      .pend_o(pend_w[g])
    );
  end

  // level flags from busy or pending channels
  always_comb begin
    lvl_w = '0;
    for (int c = 0; c < dcs_pkg::NUM_CHAN; c++) begin
      if (busy_w[c] || pend_w[c]) begin
        lvl_w[chan_level_i[c]] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Active channel word
  // ----------------------------------------------------------------
  always_comb begin
    act_word = dcs_pkg::REG_RESET;
    act_word[dcs_pkg::ACT_CNT_LSB +: dcs_pkg::CNT_W] = s_q.count;
    act_word[dcs_pkg::ACT_BUSY_BIT] = s_q.active_busy_flag;
    act_word[dcs_pkg::ACT_IDX_LSB +: dcs_pkg::IDX_W] = s_q.index;
    act_word[dcs_pkg::ACT_LVL_LSB +: dcs_pkg::NUM_LVL] = lvl_w;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = dcs_pkg::REG_RESET;
    unique case (addr_i)
      dcs_pkg::CHANNEL_INTERRUPT_SUMMARY_OFS: rd_mux[dcs_pkg::NUM_CHAN-1:0] = s_q.chint;
      dcs_pkg::CHANNEL_BUSY_FLAGS_OFS: rd_mux[dcs_pkg::NUM_CHAN-1:0] = busy_w;
      dcs_pkg::CHANNEL_PENDING_FLAGS_OFS: rd_mux[dcs_pkg::NUM_CHAN-1:0] = pend_w;
      dcs_pkg::ACTIVE_CHANNEL_STATE_OFS: rd_mux = act_word;
      dcs_pkg::IRQ_STATUS_OFS: rd_mux[dcs_pkg::IRQ_W-1:0] = s_q.irq_status;
      dcs_pkg::IRQ_MASK_OFS: rd_mux[dcs_pkg::IRQ_W-1:0] = s_q.irq_mask;
      default: rd_mux = dcs_pkg::REG_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    irq_evt = '0;

    // pending whenever an enabled source is set
    // drops with disable or source clear
    s_d.chint = chan_irq_flags_i & chan_irq_enables_i;
    if (|(s_d.chint & ~s_q.chint)) begin
      irq_evt[dcs_pkg::IRQ_CHINT_BIT] = 1'b1;
    end

    s_d.wb_valid = 1'b0;
    if (count_update_i && s_q.active_busy_flag) begin
      s_d.count = count_update_data_i;
    end

    unique case (s_q.slot)
      dcs_pkg::DCS_IDLE: begin
        if (grant_i) begin
          s_d.index = grant_index_i;
          s_d.slot = dcs_pkg::DCS_LOADED;
          irq_evt[dcs_pkg::IRQ_GRANT_BIT] = 1'b1;
        end
      end
      dcs_pkg::DCS_LOADED: begin
        if (grant_i) begin
          // old count goes back on a new grant
          s_d.wb_valid = 1'b1;
          s_d.wb_index = s_q.index;
          s_d.wb_count = s_q.count;
          s_d.active_busy_flag = 1'b0;
          s_d.index = grant_index_i;
          irq_evt[dcs_pkg::IRQ_GRANT_BIT] = 1'b1;
          irq_evt[dcs_pkg::IRQ_WRBACK_BIT] = 1'b1;
        end
      end
    endcase

    // busy rises when the next count is loaded
    if (count_load_i && s_q.slot == dcs_pkg::DCS_LOADED && !grant_i) begin
      s_d.active_busy_flag = 1'b1;
      s_d.count = count_load_data_i;
    end

    if (wr_i && addr_i == dcs_pkg::IRQ_MASK_OFS) begin
      s_d.irq_mask = wdata_i[dcs_pkg::IRQ_W-1:0];
    end
    if (wr_i && addr_i == dcs_pkg::IRQ_STATUS_OFS) begin
      s_d.irq_status = s_q.irq_status & ~wdata_i[dcs_pkg::IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    s_d.irq_status = s_d.irq_status | irq_evt;

    s_d.rdata = rd_i ? rd_mux : dcs_pkg::REG_RESET;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // count is only meaningful with active busy set
  assign rdata_o = s_q.rdata;
  assign wrback_valid_o = s_q.wb_valid;
  assign wrback_index_o = s_q.wb_index;
  assign wrback_count_o = s_q.wb_count;
  assign irq_o = |(s_q.irq_status & s_q.irq_mask);
endmodule // dcs_status_view

// ==== tb/dcs_status_view_chk.sv ====
// Checker: port-level properties of the DMA status view
module dcs_status_view_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [11:0] chan_irq_flags_i,
  input wire logic [11:0] chan_irq_enables_i,
  input wire logic [11:0] chan_start_i,
  input wire logic [11:0] chan_done_i,
  input wire logic [11:0] chan_bus_err_i,
  input wire logic [11:0] chan_disable_i,
  input wire logic [11:0] chan_exec_start_i,
  input wire logic grant_i,
  input wire logic count_load_i,
  input wire logic [15:0] count_load_data_i,
  input wire logic wrback_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ------------------------------------
  // Read-back of channel 0 events and upper zero bits, write-back cause, active slot count loads
  // ------------------------------------
  upper_zero_a: assert property (rd_i && addr_i inside {8'h24, 8'h28, 8'h2c}
    |=> rdata_o[31:12] == '0) else $error("upper bits set");
  irq_set_a: assert property (chan_irq_flags_i[0] && chan_irq_enables_i[0]
    ##1 rd_i && addr_i == 8'h24 |=> rdata_o[0]) else $error("irq flag missing");
  irq_drop_a: assert property (!chan_irq_enables_i[0]
    ##1 rd_i && addr_i == 8'h24 |=> !rdata_o[0]) else $error("irq flag stuck");
  busy_set_a: assert property (chan_start_i[0] && !(chan_done_i[0] | chan_bus_err_i[0]
    | chan_disable_i[0]) ##1 rd_i && addr_i == 8'h28 |=> rdata_o[0]) else $error("no busy");
  busy_clear_a: assert property (chan_done_i[0] ##1 rd_i && addr_i == 8'h28
    |=> !rdata_o[0]) else $error("busy stuck");
  pend_clear_a: assert property (chan_exec_start_i[0] ##1 rd_i && addr_i == 8'h2c
    |=> !rdata_o[0]) else $error("pending stuck");
  wrback_cause_a: assert property (wrback_valid_o |-> $past(grant_i))
    else $error("writeback without grant");
  active_busy_flag_load_a: assert property (count_load_i && !grant_i ##1 rd_i && addr_i == 8'h30
    |=> rdata_o[15]) else $error("active busy missing");
  count_load_a: assert property (count_load_i && !grant_i ##1 rd_i && addr_i == 8'h30
    |=> rdata_o[31:16] == $past(count_load_data_i, 2)) else $error("count wrong");
endmodule // dcs_status_view_chk

bind dcs_status_view dcs_status_view_chk u_dcs_status_view_chk (.clk_i, .reset_n_i,
  .addr_i, .rd_i, .rdata_o, .chan_irq_flags_i, .chan_irq_enables_i, .chan_start_i,
  .chan_done_i, .chan_bus_err_i, .chan_disable_i, .chan_exec_start_i, .grant_i,
  .count_load_i, .count_load_data_i, .wrback_valid_o);

// ==== tb/dcs_status_view_bench.sv ====
// Bench: self-checking run of the DMA status view
module dcs_status_view_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, reset_n_i, wr_i, rd_i, grant_i, count_load_i, count_update_i, wrback_valid_o, irq_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [11:0] chan_irq_flags_i, chan_irq_enables_i, chan_start_i, chan_done_i;
  logic [11:0] chan_bus_err_i, chan_disable_i, chan_pend_req_i, chan_exec_start_i;
  logic [1:0] chan_level_i [12];
  logic [4:0] grant_index_i, wrback_index_o;
  logic [15:0] count_load_data_i, count_update_data_i, wrback_count_o;
  int err_count, compares;
  dcs_status_view u_dcs_status_view (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .chan_irq_flags_i, .chan_irq_enables_i, .chan_start_i, .chan_done_i,
    .chan_bus_err_i, .chan_disable_i, .chan_pend_req_i, .chan_exec_start_i, .chan_level_i,
    .grant_i, .grant_index_i, .count_load_i, .count_load_data_i, .count_update_i,
    .count_update_data_i, .wrback_valid_o, .wrback_index_o, .wrback_count_o, .irq_o);
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read strobe raised in the current time step, so it may follow an edge directly
  task rdnow(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge clk_i);
    rdnow(a, e, m);
  endtask
  // One-cycle channel event: 0 start 1 done 2 error 3 disable 4 pend 5 exec
  task ev(input int k, input int c);
    @(posedge clk_i);
    case (k)
      0: chan_start_i[c] <= 1'b1;
      1: chan_done_i[c] <= 1'b1;
      2: chan_bus_err_i[c] <= 1'b1;
      3: chan_disable_i[c] <= 1'b1;
      4: chan_pend_req_i[c] <= 1'b1;
      default: chan_exec_start_i[c] <= 1'b1;
    endcase
    @(posedge clk_i);
    {chan_start_i, chan_done_i, chan_bus_err_i, chan_disable_i} <= '0;
    {chan_pend_req_i, chan_exec_start_i} <= '0;
  endtask
  // Event then an immediate read, so the read lands one cycle after the event
  task evrd(input int k, input int c, input logic [7:0] a, input logic [31:0] e);
    ev(k, c);
    rdnow(a, e);
  endtask
  // ------------------------------------
  // Scenarios
  // ------------------------------------
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      rd(8'h24 + 8'(4 * i), '0);
      wr(8'h24 + 8'(4 * i), '1);
      rd(8'h24 + 8'(4 * i), '0);
    end
    rd(8'h10, '0);
  endtask
  task t_irq;
    wr(8'h54, 32'h4);
    chan_irq_enables_i <= 12'h801;
    chan_irq_flags_i <= 12'h801;
    rd(8'h24, 32'h801);
    for (int i = 0; i < 8 && irq_o !== 1'b1; i++) @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    chan_irq_enables_i <= 12'h001;
    rd(8'h24, 32'h1);
    chan_irq_flags_i <= 12'h0;
    rd(8'h24, 32'h0);
    rd(8'h50, 32'h4);
    wr(8'h54, 32'h0);
    #1 chk(32'(irq_o), 32'h0);
    wr(8'h50, 32'h4);
    wr(8'h54, 32'h4);
    #1 chk(32'(irq_o), 32'h0);
    rd(8'h50, 32'h0);
  endtask
  task t_flags;
    evrd(0, 5, 8'h28, 32'h20);
    rd(8'h30, 32'h4);
    evrd(1, 5, 8'h28, 32'h0);
    ev(0, 11);
    rd(8'h28, 32'h800);
    ev(4, 5);
    rd(8'h2c, 32'h20);
    ev(3, 11);
    rd(8'h30, 32'h4);
    evrd(5, 5, 8'h2c, 32'h0);
    for (int k = 2; k < 4; k++) begin
      ev(0, 5);
      ev(4, 5);
      ev(k, 5);
      rd(8'h28, 32'h0);
      rd(8'h2c, 32'h0);
    end
  endtask
  task gr(input logic [4:0] idx);
    @(posedge clk_i);
    grant_i <= 1'b1;
    grant_index_i <= idx;
    @(posedge clk_i);
    grant_i <= 1'b0;
  endtask
  task t_active;
    gr(5'd3);
    rd(8'h30, 32'h300);
    count_load_i <= 1'b1;
    count_load_data_i <= 16'h0010;
    @(posedge clk_i);
    count_load_i <= 1'b0;
    rdnow(8'h30, 32'h0010_8300);
    count_update_i <= 1'b1;
    count_update_data_i <= 16'h000f;
    @(posedge clk_i);
    count_update_i <= 1'b0;
    rd(8'h30, 32'h000f_8300);
    gr(5'd11);
    #1;
    for (int i = 0; i < 4 && wrback_valid_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(32'(wrback_valid_o), 32'h1);
    chk({11'h0, wrback_index_o, wrback_count_o}, {11'h0, 5'd3, 16'h000f});
    rd(8'h30, 32'h0b00, 32'hffff);
    rd(8'h50, 32'h3, 32'h3);
  endtask
  task final_report;
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {reset_n_i, wr_i, rd_i, grant_i, count_load_i, count_update_i} = '0;
    {addr_i, wdata_i, grant_index_i, count_load_data_i, count_update_data_i} = '0;
    {chan_irq_flags_i, chan_irq_enables_i, chan_start_i, chan_done_i} = '0;
    {chan_bus_err_i, chan_disable_i, chan_pend_req_i, chan_exec_start_i} = '0;
    chan_level_i = '{default: 2'd0};
    chan_level_i[5] = 2'd2;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset;
    t_irq;
    t_flags;
    t_active;
    final_report;
  end
  // Hang guard: the whole run needs far fewer cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("[ERR] %0t timeout", $time);
    final_report;
  end
endmodule // dcs_status_view_bench
